// ---- hdl/sbap_map.svh ----
// constants for the system bus address phase: bit positions and widths
// assumes inclusion by bare name from both ends and the package
`ifndef SBAP_MAP_SVH
`define SBAP_MAP_SVH
`define SBAP_ADDR_HI 35
`define SBAP_ADDR_LO 3
`define SBAP_ADDR_W 33
`define SBAP_LANE1_LO 24
`define SBAP_LANE0_HI 23
`define SBAP_MASK_BIT 20
`define SBAP_REQ_W 5
`define SBAP_CFG_ADDRESS_PARITY_ERROR_BIT 0
`define SBAP_CFG_BUS_ERROR_LINE_BIT 1
`endif

// ---- hdl/sbap_pkg.sv ----
// types shared by both address phase ends
// assumes sbap_map.svh is on the include path
`include "sbap_map.svh"
package sbap_pkg;
    typedef logic [`SBAP_ADDR_HI:`SBAP_ADDR_LO] sbap_addr_t;
    typedef logic [`SBAP_REQ_W-1:0] sbap_req_t;

    // returns the two active-low parity lanes for an active-low address
    function automatic logic [1:0] sbap_parity(input sbap_addr_t addrN);
        logic [1:0] p;
        // parity high when an even count of covered lines are low
        p[1] = ~(^(~addrN[`SBAP_ADDR_HI:`SBAP_LANE1_LO]));
        p[0] = ~(^(~addrN[`SBAP_LANE0_HI:`SBAP_ADDR_LO]));
        return p;
    endfunction : sbap_parity
endpackage : sbap_pkg

// ---- hdl/sbap_bus_if.sv ----
// shared address phase wires between the device and another bus agent
// each two-way line carries output, enable per end; wire level resolved here
`timescale 1ns/1ns
`include "sbap_map.svh"
interface sbap_bus_if;
    logic [`SBAP_ADDR_HI:`SBAP_ADDR_LO] devA, agtA, busA;
    logic devAOe, agtAOe;
    logic devStrobeN, agtStrobeN, devStrobeOe, agtStrobeOe, busStrobeN;
    logic [1:0] devParN, agtParN, busParN;
    logic [`SBAP_REQ_W-1:0] devReqN, agtReqN, busReqN;
    logic devRpN, agtRpN, busRpN;
    logic devAerrN, agtAerrN, devAerrOe, agtAerrOe, busAerrN;
    logic devBerrN, agtBerrN, devBerrOe, agtBerrOe, busBerrN;
    logic trdyN;
    logic a20MaskN;
    logic resetN;

    // open-drain style wired-and of active-low lines
    assign busA = (devAOe ? devA : '1) & (agtAOe ? agtA : '1);
    assign busParN = (devAOe ? devParN : 2'h3) & (agtAOe ? agtParN : 2'h3);
    assign busReqN = (devAOe ? devReqN : '1) & (agtAOe ? agtReqN : '1);
    assign busRpN = (devAOe ? devRpN : 1'h1) & (agtAOe ? agtRpN : 1'h1);
    assign busStrobeN = (devStrobeOe ? devStrobeN : 1'h1)
        & (agtStrobeOe ? agtStrobeN : 1'h1);
    assign busAerrN = (devAerrOe ? devAerrN : 1'h1)
        & (agtAerrOe ? agtAerrN : 1'h1);
    assign busBerrN = (devBerrOe ? devBerrN : 1'h1)
        & (agtBerrOe ? agtBerrN : 1'h1);

    modport dev (
        output devA, devAOe, devStrobeN, devStrobeOe, devParN, devReqN,
        devRpN, devAerrN, devAerrOe, devBerrN, devBerrOe,
        input busA, busStrobeN, busParN, busReqN, busRpN, busAerrN,
        busBerrN, trdyN, a20MaskN, resetN
    );
    modport agt (
        output agtA, agtAOe, agtStrobeN, agtStrobeOe, agtParN, agtReqN,
        agtRpN, agtAerrN, agtAerrOe, agtBerrN, agtBerrOe, trdyN,
        a20MaskN, resetN,
        input busA, busStrobeN, busParN, busReqN, busRpN, busAerrN,
        busBerrN
    );
endinterface : sbap_bus_if

// ---- hdl/sbap_device.sv ----
// device end of the address phase: request drive, parity check, abort,
// power-on configuration capture and bus error drive
// assumes one clock mclk (rising edge is the bus sample point)
`timescale 1ns/1ns
`include "sbap_map.svh"
// Notes on behaviour
// RULE_01: mask clears address bit 20 before issue
// RULE_02: mask asserted only in real mode
// RULE_03: mask valid by target ready of write
// RULE_04: address bits 35..3, shared by all
// RULE_05: strobe cycle carries address, else type
// RULE_06: upper lane 35..24, lower 23..3
// RULE_07: parity high on even low count
// RULE_08: initiator drives parity with strobe, request
// RULE_09: configuration sampled from address at reset release
// RULE_10: strobe starts checking of new transaction
// RULE_11: configured error observation aborts transaction
// RULE_12: central agent handles error if unobserved
// RULE_13: all on rising clock edge
// RULE_14: may drive bus error, never observes
// RULE_15: observed errors raise bus error line
// RULE_16: receiver recomputes lanes, flags mismatch
module sbap_device (
    input wire logic mclk,
    input wire logic srst,
    sbap_bus_if.dev bus,
    input wire logic issueReq,
    input wire sbap_pkg::sbap_addr_t issueAddr,
    input wire sbap_pkg::sbap_req_t issueType,
    input wire logic internalErr,
    output logic issueBusy,
    output logic issueAbort,
    output logic parityErr,
    output logic snoopValid,
    output sbap_pkg::sbap_addr_t snoopAddr,
    output logic cfgAerrObserve,
    output logic cfgBerrDrive,
    output logic maskActive
);
    // mask pin: three flops, change accepted when last two agree
    logic [2:0] maskSync_q;
    logic maskLevel_q;
    logic [2:0] rstSync_q;
    logic rstLevel_q;
    logic [5:0] strapPipe_q;
    logic phase_q;
    logic strobeSeen_q;
    logic aerrDrive_q;
    logic [1:0] aerrWin_q;
    logic berrDrive_q;
    sbap_pkg::sbap_addr_t outA_q;
    logic [1:0] outPar_q;
    sbap_pkg::sbap_req_t outReq_q;
    logic outRp_q;
    logic driving_q;
    sbap_pkg::sbap_addr_t maskedAddr;
    logic [1:0] rxPar;

    always_ff @(posedge mclk) begin // RULE_13
        if (srst) begin
            maskSync_q <= 3'h7;
            maskLevel_q <= 1'h0;
        end else begin
            maskSync_q <= {maskSync_q[1:0], bus.a20MaskN};
            if (maskSync_q[2] == maskSync_q[1]) begin
                maskLevel_q <= ~maskSync_q[2];
            end
        end
    end

    always_comb begin
        maskedAddr = issueAddr;
        // active-low line: a forced zero address bit drives high
        if (maskLevel_q) begin
            maskedAddr[`SBAP_MASK_BIT] = 1'h0; // RULE_01
        end
    end

    // reset pin resync; configuration caught on the same edge that release is accepted
    always_ff @(posedge mclk) begin
        if (srst) begin
            rstSync_q <= 3'h0;
            rstLevel_q <= 1'h0;
        end else begin
            rstSync_q <= {rstSync_q[1:0], bus.resetN};
            if (rstSync_q[2] == rstSync_q[1]) begin
                rstLevel_q <= rstSync_q[2];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfgAerrObserve <= 1'h0;
            cfgBerrDrive <= 1'h0;
        end else if (!rstLevel_q && rstSync_q[2] && rstSync_q[1]) begin
            // configuration values are active-low on the address lines
            cfgAerrObserve <= ~strapPipe_q[4];
            cfgBerrDrive <= ~strapPipe_q[5];
        end // RULE_09
    end

    // straps delayed as long as the resync chain: the far end may let go
    // of the lines right after release, long before release is accepted
    always_ff @(posedge mclk) begin
        if (srst) begin
            strapPipe_q <= 6'h3f;
        end else begin
            strapPipe_q <= {strapPipe_q[3:0],
                bus.busA[`SBAP_ADDR_LO + `SBAP_CFG_BUS_ERROR_LINE_BIT],
                bus.busA[`SBAP_ADDR_LO + `SBAP_CFG_ADDRESS_PARITY_ERROR_BIT]}; // RULE_09
        end
    end

    // two-cycle request: address with strobe, then type information
    always_ff @(posedge mclk) begin
        if (srst) begin
            phase_q <= 1'h0;
            driving_q <= 1'h0;
            outA_q <= '1;
            outPar_q <= 2'h3;
            outReq_q <= '1;
            outRp_q <= 1'h1;
        end else if (!phase_q && issueReq && rstLevel_q && !driving_q) begin
            phase_q <= 1'h1;
            driving_q <= 1'h1;
            outA_q <= ~maskedAddr; // RULE_05
            outPar_q <= sbap_pkg::sbap_parity(~maskedAddr); // RULE_08
            outReq_q <= ~issueType;
            outRp_q <= ~(^issueType);
        end else if (phase_q) begin
            phase_q <= 1'h0;
            outA_q <= {{(`SBAP_ADDR_W - `SBAP_REQ_W){1'h1}}, ~issueType};
        end else begin
            driving_q <= 1'h0;
            outA_q <= '1;
            outPar_q <= 2'h3;
            outReq_q <= '1;
        end
    end

    assign bus.devA = outA_q;
    assign bus.devAOe = driving_q; // RULE_04
    assign bus.devParN = outPar_q;
    assign bus.devReqN = outReq_q;
    assign bus.devRpN = outRp_q;
    assign bus.devStrobeN = ~phase_q;
    assign bus.devStrobeOe = driving_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            issueBusy <= 1'h0;
            maskActive <= 1'h0;
        end else begin
            issueBusy <= phase_q | (!phase_q && issueReq && rstLevel_q);
            maskActive <= maskLevel_q;
        end
    end

    // receive side: any strobe, own or foreign
    assign rxPar = sbap_pkg::sbap_parity(bus.busA); // RULE_06 RULE_07

    always_ff @(posedge mclk) begin
        if (srst) begin
            strobeSeen_q <= 1'h0;
            snoopValid <= 1'h0;
            snoopAddr <= '0;
            parityErr <= 1'h0;
        end else begin
            strobeSeen_q <= ~bus.busStrobeN;
            snoopValid <= ~bus.busStrobeN; // RULE_10
            if (!bus.busStrobeN) begin
                snoopAddr <= ~bus.busA;
            end
            parityErr <= ~bus.busStrobeN && (rxPar != bus.busParN); // RULE_16
        end
    end

    // error line driven one cycle; observed in the three cycles after strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            aerrDrive_q <= 1'h0;
            aerrWin_q <= 2'h0;
            issueAbort <= 1'h0;
        end else begin
            aerrDrive_q <= ~bus.busStrobeN && (rxPar != bus.busParN);
            aerrWin_q <= {aerrWin_q[0], strobeSeen_q};
            issueAbort <= cfgAerrObserve && !bus.busAerrN
                && (strobeSeen_q || aerrWin_q != 2'h0); // RULE_11
        end
    end

    assign bus.devAerrN = ~aerrDrive_q;
    assign bus.devAerrOe = aerrDrive_q;

    // the line is never read back here, only driven
    always_ff @(posedge mclk) begin
        if (srst) begin
            berrDrive_q <= 1'h0;
        end else begin
            berrDrive_q <= cfgBerrDrive
                && (internalErr || aerrDrive_q); // RULE_14 RULE_15
        end
    end

    assign bus.devBerrN = ~berrDrive_q;
    assign bus.devBerrOe = berrDrive_q;
endmodule : sbap_device

// ---- hdl/sbap_agent.sv ----
// far agent end: issues requests, checks parity, raises error lines,
// drives reset, configuration straps, mask and target ready
// assumes one clock mclk shared with the device
`timescale 1ns/1ns
`include "sbap_map.svh"
module sbap_agent (
    input wire logic mclk,
    input wire logic srst,
    sbap_bus_if.agt bus,
    input wire logic holdReset,
    input wire logic [1:0] cfgStrap,
    input wire logic realMode,
    input wire logic maskReq,
    input wire logic trdyReq,
    input wire logic issueReq,
    input wire sbap_pkg::sbap_addr_t issueAddr,
    input wire sbap_pkg::sbap_req_t issueType,
    input wire logic corruptParity,
    output logic parityErr,
    output logic aerrSeen,
    output logic berrSeen,
    output logic snoopValid,
    output sbap_pkg::sbap_addr_t snoopAddr
);
    logic resetN_q;
    logic maskN_q;
    logic trdyN_q;
    logic phase_q;
    logic driving_q;
    logic address_parity_error_q;
    logic bus_error_line_q;
    sbap_pkg::sbap_addr_t outA_q;
    logic [1:0] outPar_q;
    sbap_pkg::sbap_req_t outReq_q;
    logic [1:0] rxPar;

    always_ff @(posedge mclk) begin // RULE_13
        if (srst) begin
            resetN_q <= 1'h0;
            maskN_q <= 1'h1;
            trdyN_q <= 1'h1;
        end else begin
            resetN_q <= ~holdReset;
            maskN_q <= ~(maskReq && realMode); // RULE_02 RULE_03
            trdyN_q <= ~trdyReq;
        end
    end

    assign bus.resetN = resetN_q;
    assign bus.a20MaskN = maskN_q;
    assign bus.trdyN = trdyN_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            phase_q <= 1'h0;
            driving_q <= 1'h0;
            outA_q <= '1;
            outPar_q <= 2'h3;
            outReq_q <= '1;
        end else if (!resetN_q) begin
            // straps on the address lines until past reset release
            driving_q <= 1'h1;
            outA_q <= {{(`SBAP_ADDR_W - 2){1'h1}}, ~cfgStrap}; // RULE_09
        end else if (!phase_q && issueReq && !driving_q) begin
            phase_q <= 1'h1;
            driving_q <= 1'h1;
            outA_q <= ~issueAddr;
            outPar_q <= sbap_pkg::sbap_parity(~issueAddr)
                ^ {1'h0, corruptParity}; // RULE_06 RULE_07 RULE_08
            outReq_q <= ~issueType;
        end else if (phase_q) begin
            phase_q <= 1'h0;
            outA_q <= {{(`SBAP_ADDR_W - `SBAP_REQ_W){1'h1}}, ~issueType};
        end else begin
            driving_q <= 1'h0;
            outA_q <= '1;
            outPar_q <= 2'h3;
            outReq_q <= '1;
        end
    end

    assign bus.agtA = outA_q;
    assign bus.agtAOe = driving_q;
    assign bus.agtParN = outPar_q;
    assign bus.agtReqN = outReq_q;
    assign bus.agtRpN = ~(^issueType);
    assign bus.agtStrobeN = ~phase_q; // RULE_05
    assign bus.agtStrobeOe = driving_q && resetN_q;

    assign rxPar = sbap_pkg::sbap_parity(bus.busA);

    always_ff @(posedge mclk) begin
        if (srst) begin
            parityErr <= 1'h0;
            snoopValid <= 1'h0;
            snoopAddr <= '0;
            address_parity_error_q <= 1'h0;
            bus_error_line_q <= 1'h0;
            aerrSeen <= 1'h0;
            berrSeen <= 1'h0;
        end else begin
            parityErr <= ~bus.busStrobeN && (rxPar != bus.busParN); // RULE_16
            snoopValid <= ~bus.busStrobeN; // RULE_10
            if (!bus.busStrobeN) begin
                snoopAddr <= ~bus.busA; // RULE_04
            end
            address_parity_error_q <= ~bus.busStrobeN && (rxPar != bus.busParN);
            // bus error drive follows the system option on the straps
            bus_error_line_q <= address_parity_error_q && cfgStrap[1]; // RULE_15
            aerrSeen <= ~bus.busAerrN; // RULE_12
            berrSeen <= ~bus.busBerrN;
        end
    end

    assign bus.agtAerrN = ~address_parity_error_q;
    assign bus.agtAerrOe = address_parity_error_q;
    assign bus.agtBerrN = ~bus_error_line_q;
    assign bus.agtBerrOe = bus_error_line_q;
endmodule : sbap_agent

// ---- tb/sbap_chk.sv ----
// checker for the address phase wires joining the two ends
// assumes one clock, sync reset, inputs tied to interface signals
`timescale 1ns/1ns
module sbap_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [35:3] busA,
    input wire logic busStrobeN,
    input wire logic [1:0] busParN,
    input wire logic devAOe,
    input wire logic agtAOe,
    input wire logic devStrobeOe,
    input wire logic busAerrN,
    input wire logic busBerrN,
    input wire logic a20MaskN
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // receiver verdict, kept since the lines carry type info next cycle
    logic parBad_q;
    always_ff @(posedge mclk) begin
        if (srst) begin
            parBad_q <= 1'b0;
        end else begin
            parBad_q <= busParN != {~^(~busA[35:24]), ~^(~busA[23:3])};
        end
    end

    property p_par_up;
        !busStrobeN |-> busParN[1] == ~^(~busA[35:24]);
    endproperty
    a_par_up: assert property (p_par_up)
        else $error("upper parity lane wrong");
    property p_par_lo;
        !busStrobeN && devStrobeOe |-> busParN[0] == ~^(~busA[23:3]);
    endproperty
    a_par_lo: assert property (p_par_lo)
        else $error("lower parity lane wrong");
    property p_oe_req;
        !busStrobeN |-> devAOe || agtAOe;
    endproperty
    a_oe_req: assert property (p_oe_req)
        else $error("strobe without address drive");
    property p_space;
        !busStrobeN |=> busStrobeN [*2];
    endproperty
    a_space: assert property (p_space)
        else $error("strobe too long or too close");
    property p_oe_two;
        !busStrobeN && devStrobeOe |=> devAOe ##1 !devAOe;
    endproperty
    a_oe_two: assert property (p_oe_two)
        else $error("address drive not two cycles");
    property p_mask;
        !a20MaskN [*8] ##0 (!busStrobeN && devStrobeOe) |-> busA[20];
    endproperty
    a_mask: assert property (p_mask)
        else $error("address bit 20 not masked");
    property p_address_parity_error;
        !busStrobeN |=> busAerrN == !parBad_q;
    endproperty
    a_address_parity_error: assert property (p_address_parity_error)
        else $error("parity error line wrong");
    property p_bus_error_line;
        $fell(busBerrN) |-> !$past(busAerrN);
    endproperty
    a_bus_error_line: assert property (p_bus_error_line)
        else $error("bus error without cause");

    c_dev: cover property (!busStrobeN && devStrobeOe);
    c_agt: cover property (!busStrobeN && agtAOe && !devAOe);
    c_address_parity_error: cover property (!busAerrN);
    c_bus_error_line: cover property (!busBerrN);
endmodule : sbap_chk

// ---- tb/system_bus_address_phase_tb_top.sv ----
// top bench: device and agent ends joined by the bus interface
// assumes design files and sbap_map.svh are compiled first
`timescale 1ns/1ns
module system_bus_address_phase_tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic holdReset = 1'b1;
    logic [1:0] strap = 2'h3;
    logic realMode = 1'b0;
    logic maskReq = 1'b0;
    logic devReq = 1'b0;
    logic agtReq = 1'b0;
    logic bad = 1'b0;
    sbap_pkg::sbap_addr_t addr = '0;
    sbap_pkg::sbap_req_t typ = '0;
    sbap_pkg::sbap_addr_t pat[4] = '{'0, '1, 33'h000200000, 33'h000100000};
    logic dBusy, dAbort, dPerr, dValid, cfgObs, cfgBerr, maskOn;
    logic aPerr, aAerr, aBerr, aValid, typNext;
    logic gotPerr, gotAerr, gotBerr, gotAbort;
    sbap_pkg::sbap_addr_t dAddr, aAddr, gotAddr;
    logic [4:0] gotType, nt;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 mclk = ~mclk;

    sbap_bus_if bus ();
    sbap_device u_sbap_device (.mclk(mclk), .srst(srst), .bus(bus.dev),
        .issueReq(devReq), .issueAddr(addr), .issueType(typ),
        .internalErr(1'b0), .issueBusy(dBusy), .issueAbort(dAbort),
        .parityErr(dPerr), .snoopValid(dValid), .snoopAddr(dAddr),
        .cfgAerrObserve(cfgObs), .cfgBerrDrive(cfgBerr),
        .maskActive(maskOn));
    sbap_agent u_sbap_agent (.mclk(mclk), .srst(srst), .bus(bus.agt),
        .holdReset(holdReset), .cfgStrap(strap), .realMode(realMode),
        .maskReq(maskReq), .trdyReq(maskReq), .issueReq(agtReq),
        .issueAddr(addr), .issueType(typ), .corruptParity(bad),
        .parityErr(aPerr), .aerrSeen(aAerr), .berrSeen(aBerr),
        .snoopValid(aValid), .snoopAddr(aAddr));
    sbap_chk u_sbap_chk (.mclk(mclk), .srst(srst), .busA(bus.busA),
        .busStrobeN(bus.busStrobeN), .busParN(bus.busParN),
        .devAOe(bus.devAOe), .agtAOe(bus.agtAOe),
        .devStrobeOe(bus.devStrobeOe), .busAerrN(bus.busAerrN),
        .busBerrN(bus.busBerrN), .a20MaskN(bus.a20MaskN));

    task automatic chk(input string what, input logic [35:0] exp,
        input logic [35:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset(input logic [1:0] s);
        @(negedge mclk);
        srst = 1'b1;
        holdReset = 1'b1;
        strap = s;
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        holdReset = 1'b0;
        repeat (10) @(negedge mclk);
        chk("cfgObs", s[0], cfgObs);
        chk("cfgBerr", s[1], cfgBerr);
    endtask : do_reset

    // one request from either end, receiver results gathered over 8 cycles
    task automatic xfer(input logic fromDev, input sbap_pkg::sbap_addr_t a,
        input sbap_pkg::sbap_req_t t, input logic corrupt);
        sbap_pkg::sbap_addr_t e;
        e = a;
        if (fromDev && maskReq) e[20] = 1'b0;
        nt = ~t;
        devReq = fromDev;
        agtReq = !fromDev;
        addr = a;
        typ = t;
        bad = corrupt;
        {gotPerr, gotAerr, gotBerr, gotAbort, typNext} = '0;
        gotAddr = ~e;
        gotType = t;
        @(negedge mclk);
        devReq = 1'b0;
        agtReq = 1'b0;
        // strobe stands in this cycle, type information in the next
        typNext = !bus.busStrobeN;
        chk("busy", fromDev, dBusy);
        repeat (8) begin
            @(negedge mclk);
            if (typNext) gotType = bus.busA[7:3];
            typNext = !bus.busStrobeN;
            if (fromDev ? aValid : dValid) gotAddr = fromDev ? aAddr : dAddr;
            gotPerr |= fromDev ? aPerr : dPerr;
            gotAerr |= aAerr;
            gotBerr |= aBerr;
            gotAbort |= dAbort;
        end
        bad = 1'b0;
        chk("addr", e, gotAddr);
        chk("type", nt, gotType);
        chk("perr", corrupt, gotPerr);
        chk("address_parity_error", corrupt, gotAerr);
        chk("bus_error_line", corrupt & strap[1], gotBerr);
        chk("abort", corrupt & strap[0], gotAbort);
    endtask : xfer

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            xfer(1'b0, 33'h0aaaa5555, 5'h0b, 1'b1);
            xfer(1'b1, 33'h155553333, 5'h14, 1'b0);
        end
        $display("test straps and errors done");
        foreach (pat[i]) xfer(i[0], pat[i], 5'(i), 1'b0);
        $display("test parity lanes done");
        realMode = 1'b1;
        maskReq = 1'b1;
        repeat (8) @(negedge mclk);
        chk("mask", 1'b1, maskOn);
        xfer(1'b1, '1, 5'h1f, 1'b0);
        maskReq = 1'b0;
        repeat (8) @(negedge mclk);
        chk("mask", 1'b0, maskOn);
        xfer(1'b1, '1, 5'h1f, 1'b0);
        $display("test address mask done");
        give_verdict();
    end
endmodule : system_bus_address_phase_tb_top
